//--- pin_ctrl.sv
// Pin sharing, reset pin, mode select and debug line control with an AHB-Lite register slave.
//
// Contract
// - Drive reset pin low 34 cycles each reset.
// - Record which source caused each reset.
// - Debug pin: mode input in reset, then link.
// - Sample mode pin at reset release; low=background.
// - Debug bit lasts sixteen debug clock ticks.
// - Open-drain line with brief driven high pulse.
// - Interrupt pin inactive unless its function enabled.
// - After reset pins are plain inputs, no pulls.
// - Peripheral drives enable; direction selects data readback.
// - Pull enable applies whenever pin is input.
// - Keypad rising sensitivity turns pull into pulldown.
// - Interrupt rising edge turns pull into pulldown.
// - Highest priority enabled module owns the pin.
// - Tolerate spurious edges to lower priority modules.
// - Start on internal self-clocked source after reset.
// - Range bit selects oscillator frequency range.
// - Priority: port lowest, alternate one, alternate two.
//
// The address map and the AHB-Lite slave port were decided locally.
`timescale 1ns/1ps

module pin_ctrl (
  input wire logic core_clk, // 100 MHz bus clock
  input wire logic sys_rst, // asynchronous power-on reset, active high
  input wire logic hsel, // AHB slave select
  input wire logic [31:0] haddr, // AHB address
  input wire logic [1:0] htrans, // AHB transfer type
  input wire logic hwrite, // AHB write
  input wire logic [2:0] hsize, // AHB size, word only
  input wire logic [31:0] hwdata, // AHB write data
  input wire logic hready, // AHB bus ready
  output logic hreadyout, // AHB slave ready
  output logic hresp, // AHB response, always OKAY
  output logic [31:0] hrdata, // AHB read data
  input wire logic int_rst_req, // internal reset source, one cycle or level
  input wire logic rst_pin_in, // reset pin level
  output logic rst_pin_oe, // reset pin pulled low when high
  output logic core_rst, // reset to the rest of the chip
  output logic bg_mode, // active background mode selected
  input wire logic dbg_pin_in, // debug mode select pin level
  output logic dbg_pin_out, // debug pin drive value
  output logic dbg_pin_oe, // debug pin drive enable
  output logic dbg_done, // debug bit finished pulse
  input wire logic irq_pin_in, // external interrupt pin level
  output logic irq_req, // interrupt request pulse
  output logic irq_level, // level for branch on interrupt pin
  output logic irq_pull_en, // interrupt pin pull device on
  output logic irq_pull_dn, // interrupt pin pull is a pulldown
  input wire logic [7:0] pad_in, // shared pad levels
  output logic [7:0] pad_out, // shared pad drive values
  output logic [7:0] pad_oe, // shared pad drive enables
  output logic [7:0] pad_pull_en, // shared pad pull devices on
  output logic [7:0] pad_pull_dn, // shared pad pulls are pulldowns
  output logic [7:0] periph_in, // synchronised pad levels to peripherals
  input wire logic [7:0] alt1_out, // alternate one drive values
  input wire logic [7:0] alt1_oe, // alternate one drive enables
  input wire logic [7:0] alt2_out, // alternate two drive values
  input wire logic [7:0] alt2_oe, // alternate two drive enables
  output logic osc_range, // oscillator frequency range
  output logic stop_rec_int, // stop recovery uses internal source
  output logic clk_ext_sel // run clock from external source
);

  pin_ctrl_pkg::top_state_s s;
  pin_ctrl_pkg::top_state_s next_s;
  logic eng_out;
  logic eng_oe;
  logic eng_busy;
  logic eng_done;
  logic eng_rx;
  logic rd_req;
  logic wr_req;
  logic irq_edge;

  // ----------------------------------------------------------------
  // Debug line engine
  // ----------------------------------------------------------------
  // The engine is enabled from the next state so that its drive drops
  // in the same edge in which any reset sequence begins.
  debug_bit_engine u_dbg (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .enable(next_s.st == pin_ctrl_pkg::ST_RUN),
    .div(s.cfg.dbg_div),
    .start(s.dbg_start),
    .tx_bit(s.dbg_tx),
    .pin_in(s.dbg_sync[1]),
    .pin_out(eng_out),
    .pin_oe(eng_oe),
    .busy(eng_busy),
    .done(eng_done),
    .rx_bit(eng_rx)
  );

  assign rd_req = hsel && htrans[1] && hready && !hwrite;
  assign wr_req = hsel && htrans[1] && hready && hwrite;
  assign irq_edge = s.cfg.irq_rise ? (s.irq_sync[1] && !s.irq_prev) : (!s.irq_sync[1] && s.irq_prev);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_s = s;
    next_s.rst_sync = {s.rst_sync[0], rst_pin_in};
    next_s.dbg_sync = {s.dbg_sync[0], dbg_pin_in};
    next_s.irq_sync = {s.irq_sync[0], irq_pin_in};
    next_s.pad_sync0 = pad_in;
    next_s.pad_sync1 = s.pad_sync0;
    next_s.irq_prev = s.irq_sync[1];
    next_s.hreadyout = 1'b1;
    next_s.soft_req = 1'b0;
    next_s.dbg_start = 1'b0;
    next_s.wr_pend = wr_req;
    next_s.wr_addr = haddr[7:0];

    if (rd_req)
    begin
      case (haddr[7:0])
        pin_ctrl_pkg::OFS_PORT_DATA:
          next_s.hrdata = {24'h000000, (s.cfg.data_dir & s.cfg.port_data) | (~s.cfg.data_dir & s.pad_sync1)};
        pin_ctrl_pkg::OFS_DATA_DIR: next_s.hrdata = {24'h000000, s.cfg.data_dir};
        pin_ctrl_pkg::OFS_PULL_EN: next_s.hrdata = {24'h000000, s.cfg.pull_en};
        pin_ctrl_pkg::OFS_ALT1_EN: next_s.hrdata = {24'h000000, s.cfg.alt1_en};
        pin_ctrl_pkg::OFS_ALT2_EN: next_s.hrdata = {24'h000000, s.cfg.alt2_en};
        pin_ctrl_pkg::OFS_PIN_LEVEL: next_s.hrdata = {24'h000000, s.pad_sync1};
        pin_ctrl_pkg::OFS_IRQ_CTRL: next_s.hrdata = {29'h0, s.cfg.irq_pull, s.cfg.irq_rise, s.cfg.irq_en};
        pin_ctrl_pkg::OFS_KPD_CTRL: next_s.hrdata = {23'h0, s.cfg.kpd_rise, s.cfg.kpd_en};
        pin_ctrl_pkg::OFS_CLK_GEN_CTRL_ONE:
          next_s.hrdata = {29'h0, s.cfg.clk_ext_sel, s.cfg.stop_rec_int, s.cfg.osc_range};
        pin_ctrl_pkg::OFS_RESET_CAUSE: next_s.hrdata = {28'h0000000, s.cause};
        pin_ctrl_pkg::OFS_SYS_CTRL: next_s.hrdata = {30'h0, s.bg_mode, 1'b0};
        pin_ctrl_pkg::OFS_DBG_CTRL:
          next_s.hrdata = {22'h0, eng_rx, eng_busy, s.cfg.dbg_div, 2'h0, s.dbg_tx, 1'b0};
        default: next_s.hrdata = 32'h00000000;
      endcase
    end

    if (s.wr_pend && s.st == pin_ctrl_pkg::ST_RUN)
    begin
      case (s.wr_addr)
        pin_ctrl_pkg::OFS_PORT_DATA: next_s.cfg.port_data = hwdata[7:0];
        pin_ctrl_pkg::OFS_DATA_DIR: next_s.cfg.data_dir = hwdata[7:0];
        pin_ctrl_pkg::OFS_PULL_EN: next_s.cfg.pull_en = hwdata[7:0];
        pin_ctrl_pkg::OFS_ALT1_EN: next_s.cfg.alt1_en = hwdata[7:0];
        pin_ctrl_pkg::OFS_ALT2_EN: next_s.cfg.alt2_en = hwdata[7:0];
        pin_ctrl_pkg::OFS_IRQ_CTRL:
        begin
          next_s.cfg.irq_en = hwdata[pin_ctrl_pkg::IRQ_EN_BIT];
          next_s.cfg.irq_rise = hwdata[pin_ctrl_pkg::IRQ_RISE_BIT];
          next_s.cfg.irq_pull = hwdata[pin_ctrl_pkg::IRQ_PULL_BIT];
        end
        pin_ctrl_pkg::OFS_KPD_CTRL:
        begin
          next_s.cfg.kpd_en = hwdata[7:0] & pin_ctrl_pkg::KPD_PIN_MASK;
          next_s.cfg.kpd_rise = hwdata[pin_ctrl_pkg::KPD_RISE_BIT];
        end
        pin_ctrl_pkg::OFS_CLK_GEN_CTRL_ONE:
        begin
          next_s.cfg.osc_range = hwdata[pin_ctrl_pkg::CLK_RANGE_BIT];
          next_s.cfg.stop_rec_int = hwdata[pin_ctrl_pkg::CLK_STOP_INT_BIT];
          next_s.cfg.clk_ext_sel = hwdata[pin_ctrl_pkg::CLK_EXT_SEL_BIT];
        end
        pin_ctrl_pkg::OFS_SYS_CTRL: next_s.soft_req = hwdata[pin_ctrl_pkg::SYS_SOFT_RST_BIT];
        pin_ctrl_pkg::OFS_DBG_CTRL:
        begin
          next_s.dbg_start = hwdata[pin_ctrl_pkg::DBG_START_BIT];
          next_s.dbg_tx = hwdata[pin_ctrl_pkg::DBG_TX_BIT];
          next_s.cfg.dbg_div = hwdata[pin_ctrl_pkg::DBG_DIV_LSB +: 4];
        end
        default: next_s.cfg = s.cfg;
      endcase
    end

    // ----------------------------------------------------------------
    // Reset sequence
    // ----------------------------------------------------------------
    case (s.st)
      pin_ctrl_pkg::ST_DRIVE:
      begin
        next_s.rst_cnt = s.rst_cnt + 6'h01;
        if (s.rst_cnt == pin_ctrl_pkg::RST_DRIVE_CYCLES - 6'h01)
          next_s.st = pin_ctrl_pkg::ST_WAIT;
      end
      pin_ctrl_pkg::ST_WAIT:
      begin
        // The pin is released here; an external source holding it low
        // keeps the chip in reset for as long as it likes.
        if (s.rst_sync[1])
        begin
          next_s.st = pin_ctrl_pkg::ST_RUN;
          next_s.bg_mode = !s.dbg_sync[1];
        end
      end
      pin_ctrl_pkg::ST_RUN:
      begin
        if (!s.rst_sync[1] || s.soft_req || int_rst_req)
        begin
          next_s.st = pin_ctrl_pkg::ST_DRIVE;
          next_s.rst_cnt = 6'h00;
          next_s.cfg = pin_ctrl_pkg::CFG_RESET;
          next_s.dbg_tx = 1'b0;
          if (!s.rst_sync[1])
            next_s.cause = 4'h1 << pin_ctrl_pkg::CAUSE_PIN;
          else if (s.soft_req)
            next_s.cause = 4'h1 << pin_ctrl_pkg::CAUSE_SOFT;
          else
            next_s.cause = 4'h1 << pin_ctrl_pkg::CAUSE_INT;
        end
      end
      default: next_s.st = pin_ctrl_pkg::ST_DRIVE;
    endcase
    next_s.rst_pin_oe = (next_s.st == pin_ctrl_pkg::ST_DRIVE);
    next_s.core_rst = (next_s.st != pin_ctrl_pkg::ST_RUN);

    // ----------------------------------------------------------------
    // Pad multiplexing
    // ----------------------------------------------------------------
    for (int i = 0; i < pin_ctrl_pkg::NPINS; i++)
    begin
      if (s.cfg.alt2_en[i])
      begin
        next_s.pad.out[i] = alt2_out[i];
        next_s.pad.oe[i] = alt2_oe[i];
      end
      else if (s.cfg.alt1_en[i])
      begin
        next_s.pad.out[i] = alt1_out[i];
        next_s.pad.oe[i] = alt1_oe[i];
      end
      else
      begin
        next_s.pad.out[i] = s.cfg.port_data[i];
        next_s.pad.oe[i] = s.cfg.data_dir[i];
      end
      next_s.pad_pull_en[i] = s.cfg.pull_en[i] && !next_s.pad.oe[i];
      next_s.pad_pull_dn[i] = pin_ctrl_pkg::KPD_PIN_MASK[i] && s.cfg.kpd_en[i] && s.cfg.kpd_rise;
    end
    // every enabled module sees the synchronised pad level; edges caused by a
    // change of owner reach it unfiltered and software discards them.
    next_s.periph_in = s.pad_sync1;

    // ----------------------------------------------------------------
    // External interrupt pin
    // ----------------------------------------------------------------
    // inactive when disabled
    next_s.irq_req = s.cfg.irq_en && irq_edge;
    next_s.irq_level = s.cfg.irq_en ? s.irq_sync[1] : 1'b1;
    next_s.irq_pull_en = s.cfg.irq_en && s.cfg.irq_pull;
    next_s.irq_pull_dn = s.cfg.irq_en && s.cfg.irq_rise;
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s <= '0;
      s.st <= pin_ctrl_pkg::ST_DRIVE;
      s.cause <= pin_ctrl_pkg::CAUSE_POR_VAL;
      s.rst_pin_oe <= 1'b1;
      s.core_rst <= 1'b1;
      s.hreadyout <= 1'b1;
      s.irq_level <= 1'b1;
    end
    else
      s <= next_s;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // internal source after reset
  assign clk_ext_sel = s.cfg.clk_ext_sel;
  assign osc_range = s.cfg.osc_range;
  assign stop_rec_int = s.cfg.stop_rec_int;
  assign hreadyout = s.hreadyout;
  assign hresp = 1'b0;
  assign hrdata = s.hrdata;
  assign rst_pin_oe = s.rst_pin_oe;
  assign core_rst = s.core_rst;
  assign bg_mode = s.bg_mode;
  // link owns pin only after reset
  assign dbg_pin_out = eng_out;
  assign dbg_pin_oe = eng_oe;
  assign dbg_done = eng_done;
  assign irq_req = s.irq_req;
  assign irq_level = s.irq_level;
  assign irq_pull_en = s.irq_pull_en;
  assign irq_pull_dn = s.irq_pull_dn;
  assign pad_out = s.pad.out;
  assign pad_oe = s.pad.oe;
  assign pad_pull_en = s.pad_pull_en;
  assign pad_pull_dn = s.pad_pull_dn;
  assign periph_in = s.periph_in;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  rst_drive_len_a: assert property ($rose(rst_pin_oe) |-> rst_pin_oe[*8] ##0 (s.rst_cnt == 6'h07))
    else $error("reset pin drive count wrong");
  rst_drive_end_a: assert property ((s.st == pin_ctrl_pkg::ST_DRIVE && s.rst_cnt == 6'h21) |=> !rst_pin_oe)
    else $error("reset pin not released after 34 cycles");
  cause_onehot_a: assert property ($onehot(s.cause))
    else $error("reset cause not one-hot");
  dbg_in_reset_a: assert property (core_rst |-> !dbg_pin_oe)
    else $error("debug pin driven during reset");
  mode_sample_a: assert property ((s.st == pin_ctrl_pkg::ST_WAIT && s.rst_sync[1]) |=> bg_mode == !$past(s.dbg_sync[1]))
    else $error("mode not sampled at reset release");
  mode_hold_a: assert property ((!core_rst && !$past(core_rst)) |-> $stable(bg_mode))
    else $error("mode changed outside reset");
  irq_disabled_a: assert property (!s.cfg.irq_en |=> (!irq_req && irq_level && !irq_pull_en))
    else $error("interrupt pin active while disabled");
  irq_pulldn_a: assert property ((s.cfg.irq_en && s.cfg.irq_rise && s.cfg.irq_pull) |=> (irq_pull_en && irq_pull_dn))
    else $error("interrupt pull not a pulldown on rising edge");
  pad_prio_a: assert property (s.cfg.alt2_en[0] |=> pad_oe[0] == $past(alt2_oe[0]))
    else $error("alternate two does not own the pad");
  pad_reset_a: assert property ($fell(core_rst) |-> (pad_oe == 8'h00 && pad_pull_en == 8'h00))
    else $error("pads not plain inputs after reset");
  pull_input_a: assert property ((s.cfg.pull_en[2] && !s.cfg.alt2_en[2] && s.cfg.alt1_en[2] && !alt1_oe[2]) |=> pad_pull_en[2])
    else $error("pull not enabled on input pad");

endmodule

//--- pin_ctrl_pkg.sv
// Shared constants, register map and state layouts for the pin sharing and reset control block.
package pin_ctrl_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NPINS = 8;
  localparam logic [7:0] KPD_PIN_MASK = 8'h0E;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_PORT_DATA = 8'h00;
  localparam logic [7:0] OFS_DATA_DIR = 8'h04;
  localparam logic [7:0] OFS_PULL_EN = 8'h08;
  localparam logic [7:0] OFS_ALT1_EN = 8'h0C;
  localparam logic [7:0] OFS_ALT2_EN = 8'h10;
  localparam logic [7:0] OFS_PIN_LEVEL = 8'h14;
  localparam logic [7:0] OFS_IRQ_CTRL = 8'h18;
  localparam logic [7:0] OFS_KPD_CTRL = 8'h1C;
  localparam logic [7:0] OFS_CLK_GEN_CTRL_ONE = 8'h20;
  localparam logic [7:0] OFS_RESET_CAUSE = 8'h24;
  localparam logic [7:0] OFS_SYS_CTRL = 8'h28;
  localparam logic [7:0] OFS_DBG_CTRL = 8'h2C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int IRQ_EN_BIT = 0;
  localparam int IRQ_RISE_BIT = 1;
  localparam int IRQ_PULL_BIT = 2;
  localparam int KPD_RISE_BIT = 8;
  localparam int CLK_RANGE_BIT = 0;
  localparam int CLK_STOP_INT_BIT = 1;
  localparam int CLK_EXT_SEL_BIT = 2;
  localparam int SYS_SOFT_RST_BIT = 0;
  localparam int SYS_BG_MODE_BIT = 1;
  localparam int DBG_START_BIT = 0;
  localparam int DBG_TX_BIT = 1;
  localparam int DBG_DIV_LSB = 4;
  localparam int DBG_BUSY_BIT = 8;
  localparam int DBG_RX_BIT = 9;
  localparam int CAUSE_POR = 0;
  localparam int CAUSE_PIN = 1;
  localparam int CAUSE_SOFT = 2;
  localparam int CAUSE_INT = 3;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [3:0] CAUSE_POR_VAL = 4'h1;
  localparam logic [5:0] RST_DRIVE_CYCLES = 6'h22;
  localparam logic [3:0] DBG_TICKS_PER_BIT = 4'hF;
  localparam logic [3:0] DBG_LOW_END = 4'h3;
  localparam logic [3:0] DBG_ZERO_END = 4'hC;
  localparam logic [3:0] DBG_SAMPLE_TICK = 4'hA;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_DRIVE = 3'b001,
    ST_WAIT = 3'b010,
    ST_RUN = 3'b100
  } rst_state_e;

  typedef struct packed {
    logic [NPINS-1:0] port_data;
    logic [NPINS-1:0] data_dir;
    logic [NPINS-1:0] pull_en;
    logic [NPINS-1:0] alt1_en;
    logic [NPINS-1:0] alt2_en;
    logic [NPINS-1:0] kpd_en;
    logic kpd_rise;
    logic irq_en;
    logic irq_rise;
    logic irq_pull;
    logic osc_range;
    logic stop_rec_int;
    logic clk_ext_sel;
    logic [3:0] dbg_div;
  } pin_cfg_s;

  localparam pin_cfg_s CFG_RESET = '0;

  typedef struct packed {
    logic [NPINS-1:0] out;
    logic [NPINS-1:0] oe;
  } pad_drive_s;

  typedef struct packed {
    logic busy;
    logic bit_val;
    logic [3:0] cnt;
    logic [3:0] div_cnt;
    logic out;
    logic oe;
    logic done;
    logic rx;
  } dbg_state_s;

  typedef struct packed {
    rst_state_e st;
    logic [5:0] rst_cnt;
    logic [3:0] cause;
    logic bg_mode;
    pin_cfg_s cfg;
    logic [1:0] rst_sync;
    logic [1:0] dbg_sync;
    logic [1:0] irq_sync;
    logic [NPINS-1:0] pad_sync0;
    logic [NPINS-1:0] pad_sync1;
    logic irq_prev;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic soft_req;
    logic dbg_start;
    logic dbg_tx;
    logic [31:0] hrdata;
    logic hreadyout;
    logic rst_pin_oe;
    logic core_rst;
    pad_drive_s pad;
    logic [NPINS-1:0] pad_pull_en;
    logic [NPINS-1:0] pad_pull_dn;
    logic [NPINS-1:0] periph_in;
    logic irq_req;
    logic irq_level;
    logic irq_pull_en;
    logic irq_pull_dn;
  } top_state_s;

endpackage

//--- debug_bit_engine.sv
// One-wire debug bit engine: sends one bit per request and samples the line.
`timescale 1ns/1ps

module debug_bit_engine (
  input wire logic core_clk, // bus clock
  input wire logic sys_rst, // asynchronous reset, active high
  input wire logic enable, // line belongs to the debug link
  input wire logic [3:0] div, // debug clock = bus clock / (div + 1)
  input wire logic start, // one-cycle request to send a bit
  input wire logic tx_bit, // bit to send
  input wire logic pin_in, // synchronised line level
  output logic pin_out, // line drive value
  output logic pin_oe, // line drive enable
  output logic busy, // bit in progress
  output logic done, // one-cycle pulse at end of bit
  output logic rx_bit // line level sampled within the bit
);

  pin_ctrl_pkg::dbg_state_s s;
  pin_ctrl_pkg::dbg_state_s next_s;
  logic tick;

  assign tick = (s.div_cnt == 4'h0);

  always_comb
  begin
    next_s = s;
    next_s.done = 1'b0;
    next_s.div_cnt = tick ? div : s.div_cnt - 4'h1;
    if (!enable)
    begin
      next_s.busy = 1'b0;
      next_s.oe = 1'b0;
      next_s.out = 1'b0;
    end
    else if (!s.busy && start)
    begin
      next_s.busy = 1'b1;
      next_s.cnt = 4'h0;
      next_s.bit_val = tx_bit;
    end
    else if (s.busy && tick)
    begin
      if (s.cnt <= pin_ctrl_pkg::DBG_LOW_END)
      begin
        next_s.oe = 1'b1;
        next_s.out = 1'b0;
      end
      else if (s.bit_val && s.cnt == pin_ctrl_pkg::DBG_LOW_END + 4'h1)
      begin
        next_s.oe = 1'b1;
        next_s.out = 1'b1;
      end
      else if (!s.bit_val && s.cnt <= pin_ctrl_pkg::DBG_ZERO_END)
      begin
        next_s.oe = 1'b1;
        next_s.out = 1'b0;
      end
      else if (!s.bit_val && s.cnt == pin_ctrl_pkg::DBG_ZERO_END + 4'h1)
      begin
        next_s.oe = 1'b1;
        next_s.out = 1'b1;
      end
      else
      begin
        next_s.oe = 1'b0;
        next_s.out = 1'b0;
      end
      if (s.cnt == pin_ctrl_pkg::DBG_SAMPLE_TICK)
      begin
        next_s.rx = pin_in;
      end
      if (s.cnt == pin_ctrl_pkg::DBG_TICKS_PER_BIT)
      begin
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
        next_s.oe = 1'b0;
      end
      next_s.cnt = s.cnt + 4'h1;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      s <= '0;
    else
      s <= next_s;
  end

  assign pin_out = s.out;
  assign pin_oe = s.oe;
  assign busy = s.busy;
  assign done = s.done;
  assign rx_bit = s.rx;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  bit_time_end_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (s.busy && tick && enable && s.cnt == 4'hF) |=> (done && !busy && !pin_oe))
    else $error("debug bit did not end after sixteen ticks");

  speedup_short_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (pin_oe && pin_out && tick && busy) |=> !(pin_oe && pin_out))
    else $error("debug line driven high longer than one tick");

endmodule

//--- debug_host.sv
// Far-side model: debug host and external reset sources on the shared pins.
`timescale 1ns/1ps
module debug_host (
  input wire logic dbg_pin_oe, // device drives the debug pin
  input wire logic dbg_pin_out, // device drive value
  input wire logic hold_low, // host forces the debug pin low
  input wire logic rst_pin_oe, // device pulls the reset pin low
  input wire logic ext_rst, // external reset switch closed
  output logic dbg_pin_in, // resolved debug pin level
  output logic rst_pin_in // resolved reset pin level
);
  // host selects background mode by holding the line low.
  assign dbg_pin_in = dbg_pin_oe ? dbg_pin_out : !hold_low;
  assign rst_pin_in = !(rst_pin_oe | ext_rst);
endmodule

//--- testbench.sv
// Self-checking bench for the pin sharing and reset control block.
`timescale 1ns/1ps
module testbench;
  logic core_clk, sys_rst, hsel, hwrite, hold_low, ext_rst, int_rst_req, hresp, irq_pin_in, h;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [7:0] pad_in, alt1_out, alt1_oe, alt2_out, alt2_oe, pad_out, pad_oe, pad_pull_en, pad_pull_dn, periph_in;
  logic hreadyout, rst_pin_in, rst_pin_oe, core_rst, bg_mode, dbg_pin_in, dbg_pin_out, dbg_pin_oe, dbg_done;
  logic irq_req, irq_level, irq_pull_en, irq_pull_dn, osc_range, stop_rec_int, clk_ext_sel;
  int miscompares, samples_checked, n, l;
  pin_ctrl uut (.core_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
    .hreadyout, .hresp, .hrdata, .int_rst_req, .rst_pin_in, .rst_pin_oe, .core_rst, .bg_mode, .dbg_pin_in,
    .dbg_pin_out, .dbg_pin_oe, .dbg_done, .irq_pin_in, .irq_req, .irq_level, .irq_pull_en, .irq_pull_dn, .pad_in,
    .pad_out, .pad_oe, .pad_pull_en, .pad_pull_dn, .periph_in, .alt1_out, .alt1_oe, .alt2_out, .alt2_oe,
    .osc_range, .stop_rec_int, .clk_ext_sel);
  debug_host host (.dbg_pin_oe, .dbg_pin_out, .hold_low, .rst_pin_oe, .ext_rst, .dbg_pin_in, .rst_pin_in);
  initial
  begin
    core_clk = 1'h0;
    forever #5 core_clk = !core_clk;
  end
  task tally_and_finish();
    if (miscompares == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task ck(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task bail();
    miscompares++;
    tally_and_finish();
  endtask
  // Slave is zero-wait, but the loops stay bounded in case it never answers.
  task xf(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge core_clk);
    hsel <= 1'h1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge core_clk); while (hreadyout !== 1'h1 && ++k < 99);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'h1 && ++k < 99);
    r = hrdata;
    if (k > 97)
      bail();
  endtask
  // Counted on falling edges so registered outputs have settled.
  task drive_len();
    n = 0;
    @(negedge core_clk);
    repeat (9) if (rst_pin_oe !== 1'h1) @(negedge core_clk);
    while (rst_pin_oe === 1'h1 && n < 99)
    begin
      n++;
      @(negedge core_clk);
    end
  endtask
  task wait_run();
    n = 0;
    while (core_rst !== 1'h0 && n < 200)
    begin
      @(negedge core_clk);
      n++;
    end
    if (n == 200)
      bail();
    @(posedge core_clk);
  endtask
  // Sends one debug bit, then counts cycles to done and cycles driven low.
  task dbg_bit(input logic [31:0] d);
    {n, h, l} = 0;
    xf(1, 8'h2C, d);
    while (dbg_done !== 1'h1 && n < 60)
    begin
      @(negedge core_clk);
      h = h | (dbg_pin_oe & dbg_pin_out);
      l = l + (dbg_pin_oe & !dbg_pin_out);
      n++;
    end
    if (n == 60)
      bail();
  endtask
  initial
  begin
    {sys_rst, hold_low, hsel, hwrite, ext_rst, int_rst_req, irq_pin_in, htrans, haddr, hwdata} = {2'h3, 71'h0};
    {pad_in, alt1_out, alt1_oe, alt2_out, alt2_oe} = 40'hA5FF0000FF;
    miscompares = 0;
    samples_checked = 0;
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'h0;
    drive_len();
    ck(n, 34);
    wait_run();
    hold_low <= 1'h0;
    ck(bg_mode, 1);
    ck({hresp, pad_oe, pad_pull_en, pad_pull_dn, irq_level, clk_ext_sel}, 27'h2);
    xf(0, 8'h24, 0);
    ck(r, 1);
    xf(1, 8'h04, 8'hFF);
    xf(1, 8'h00, 8'h55);
    xf(1, 8'h08, 8'hFF);
    xf(1, 8'h0C, 8'h0F);
    xf(1, 8'h10, 8'h03);
    xf(0, 8'h00, 0);
    ck(r, 8'h55);
    ck({pad_out, pad_oe, pad_pull_en}, 24'h5CF30C);
    ck(periph_in, 8'hA5);
    xf(1, 8'h04, 0);
    xf(0, 8'h00, 0);
    ck(r, 8'hA5);
    ck(irq_level, 1);
    xf(1, 8'h1C, 32'h1FF);
    xf(1, 8'h20, 3);
    xf(1, 8'h18, 7);
    repeat (2) @(negedge core_clk);
    ck({pad_pull_dn, osc_range, stop_rec_int, irq_pull_en, irq_pull_dn, irq_level}, 13'h1DE);
    @(posedge core_clk);
    irq_pin_in <= 1'h1;
    n = 0;
    while (irq_req !== 1'h1 && n < 9)
    begin
      @(negedge core_clk);
      n++;
    end
    ck(irq_req, 1);
    dbg_bit(32'h3);
    ck(n, 32'h12);
    ck({h, l[7:0]}, 9'h104);
    xf(0, 8'h2C, 0);
    ck(r, 32'h202);
    dbg_bit(32'h11);
    ck(n, 32'h22);
    ck({h, l[7:0]}, 9'h11A);
    xf(0, 8'h28, 0);
    ck(r, 2);
    xf(1, 8'h28, 1);
    drive_len();
    ck(n, 34);
    wait_run();
    xf(0, 8'h24, 0);
    ck({r[3:0], bg_mode, pad_pull_dn}, 13'h800);
    ext_rst <= 1'h1;
    repeat (5) @(posedge core_clk);
    ext_rst <= 1'h0;
    wait_run();
    xf(0, 8'h24, 0);
    ck(r, 2);
    int_rst_req <= 1'h1;
    @(posedge core_clk);
    int_rst_req <= 1'h0;
    drive_len();
    ck(n, 34);
    wait_run();
    xf(0, 8'h24, 0);
    ck(r, 8);
    tally_and_finish();
  end
endmodule
